// File: hw/sbp_pkg.sv
// Constants, register map and types for the shared I/O bus port.
package sbp_pkg;

  localparam int CLK_MHZ = 100;
  localparam int EB_W = 16;
  localparam int TMR_W = 8;
  localparam int SYNC_W = 21;

  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DOUT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_DIN = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_TADDR = 8'h14;
  localparam logic [7:0] REG_TOUT = 8'h18;
  localparam logic [7:0] REG_TIN = 8'h1c;
  localparam logic [7:0] REG_AREG = 8'h20;
  localparam logic [7:0] REG_BREG = 8'h24;

  // Command word fields on the shared bus.
  localparam int EB_EXC = 11;
  localparam int EB_SNS = 12;
  localparam int EB_DIN = 13;
  localparam int EB_DOUT = 14;
  localparam int EB_OP_LO = 11;
  localparam int EB_OP_HI = 14;
  localparam int EB_CLR = 8;
  localparam int EB_SEL_LO = 6;
  localparam int EB_SEL_HI = 7;
  localparam int EB_LOC_LO = 1;
  localparam logic [1:0] SEL_MEM = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;

  // Control and status bits.
  localparam int CTRL_SYSRST = 0;
  localparam int CTRL_PRIO = 1;
  localparam int CTRL_TRAP_EN = 2;
  localparam int CTRL_INT_EN = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SENSE = 1;
  localparam int STAT_INT = 2;
  localparam int STAT_TRAP = 3;
  localparam int STAT_ERR = 4;
  localparam int STAT_PRIO_IN = 5;
  localparam int STAT_IRQ = 6;
  localparam int STAT_TRAP_IN = 7;

  // Phase timing.
  localparam int ADDR_SETUP_NS = 100;
  localparam int FR_PULSE_NS = 450;
  localparam int ADDR_HOLD_NS = 100;
  localparam int DIN_WAIT_NS = 700;
  localparam int DR_PULSE_NS = 450;
  localparam int DATA_HOLD_NS = 100;
  localparam int JUMP_NS = 1000;
  localparam int IUC_KHZ = 1100;
  localparam int SETUP_CYC = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int FR_CYC = (FR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int DIN_CYC = (DIN_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int DR_CYC = (DR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DHOLD_CYC = (DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int JUMP_CYC = (JUMP_NS * CLK_MHZ + 999) / 1000;
  localparam int IUC_HALF = (CLK_MHZ * 1000) / (2 * IUC_KHZ);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_FR, ST_FHOLD, ST_GAP, ST_DR, ST_DHOLD, ST_JUMP
  } sbp_state_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_EXC, OP_SNS, OP_DIN, OP_DOUT, OP_TOUT, OP_TIN, OP_INT
  } sbp_op_t;

endpackage : sbp_pkg

// File: hw/sbp_sync.sv
// Two-stage synchroniser for inputs arriving from the cable.
`timescale 1ns/1ps
module sbp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : sbp_sync

// File: hw/sbp_iuc_div.sv
// Divider that makes the interrupt clock and stops it on demand.
`timescale 1ns/1ps
module sbp_iuc_div import sbp_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control and clock out
  input wire logic stop,
  output logic iuc
);

  localparam logic [TMR_W-1:0] HALF_M1 = TMR_W'(IUC_HALF - 1);

  logic [TMR_W-1:0] cnt_q;
  logic iuc_q;
  wire wrap = (cnt_q == HALF_M1);

  // Stopping parks the clock low so modules see a clean restart.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      iuc_q <= 1'b0;
    end else if (stop) begin
      cnt_q <= '0;
      iuc_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      iuc_q <= wrap ? ~iuc_q : iuc_q;
    end
  end

  assign iuc = iuc_q;

endmodule : sbp_iuc_div

// File: hw/sbp_io_port.sv
// Computer-side I/O section of the shared bus, with an AHB-Lite slave.
//
// Summary of operation
// - Sense/control single phase; transfers use two.
// - Every phase ends with a control pulse.
// - Lines 11-14 name the operation kind.
// - Function-ready pulse marks code or address present.
// - Acknowledge true: module address; else device address.
// - Data-ready pulse marks data, second phase.
// - Interrupt request, location placed under acknowledge.
// - Trap: address with function-ready, data with data-ready.
// - Interrupt clock 1.1 MHz, stopped under acknowledge.
// - Priority chain decides interrupt and trap modules; traps here ignore priority out.
// - Interrupt-jump line true during interrupt jump.
// - Sense code: line 12, function, device address.
// - Control code: line 11, function, device address.
// - Out line 14, in line 13, register select.
// - Line 8 clears selected register.
// - Interrupt location on lines 01 to 15.
`timescale 1ns/1ps
module sbp_io_port import sbp_pkg::*; (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Shared bus lines
  input wire logic [EB_W-1:0] ebus_i,
  output logic [EB_W-1:0] ebus_o,
  output logic ebus_oe,
  // Control lines from the computer
  output logic function_ready_pulse,
  output logic data_ready_pulse,
  output logic interrupt_acknowledge_line,
  output logic interrupt_clock_line,
  output logic interrupt_jump_line,
  output logic system_reset_line,
  output logic priority_out_line,
  // Control lines from the modules
  input wire logic sense_return_line,
  input wire logic interrupt_request_line,
  input wire logic trap_output_request,
  input wire logic trap_input_request,
  input wire logic priority_in_line
);

  // Cable inputs are asynchronous to hclk.
  logic [SYNC_W-1:0] sync_s;
  sbp_sync #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({priority_in_line, trap_input_request, trap_output_request,
        interrupt_request_line, sense_return_line, ebus_i}),
    .q(sync_s)
  );
  wire [EB_W-1:0] eb_s = sync_s[EB_W-1:0];
  wire sns_s = sync_s[EB_W];
  wire irq_s = sync_s[EB_W+1];
  wire tout_s = sync_s[EB_W+2];
  wire tin_s = sync_s[EB_W+3];
  wire pin_s = sync_s[EB_W+4];

  // AHB-Lite slave: always ready, always OKAY; reads are registered.
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_w;
  wire ahb_go = hsel && hready && htrans[1];
  wire [7:0] ra = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_q <= ahb_go && hwrite;
      waddr_q <= ahb_go ? ra : waddr_q;
      hrdata_q <= (ahb_go && !hwrite) ? rd_w : hrdata_q;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wr_cmd = wr_q && (waddr_q == REG_CMD);
  wire wr_dout = wr_q && (waddr_q == REG_DOUT);
  wire wr_stat = wr_q && (waddr_q == REG_STAT);
  wire wr_ctrl = wr_q && (waddr_q == REG_CTRL);
  wire wr_tout = wr_q && (waddr_q == REG_TOUT);
  wire wr_a = wr_q && (waddr_q == REG_AREG);
  wire wr_b = wr_q && (waddr_q == REG_BREG);

  // Software registers.
  logic [EB_W-1:0] cmd_q, dout_q, tout_q, din_q, tin_q, taddr_q, a_q, b_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic pend_q, sense_q, int_q, trap_q, err_q, tdir_q;
  logic [31:0] stat_w;

  // Sequencer state.
  sbp_state_t st_q, st_d;
  sbp_op_t op_q, op_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [EB_W-1:0] ebus_o_q, ebus_o_d;
  logic oe_q, fr_q, dr_q, ack_q, jump_q, sysrst_q, prio_q;

  wire busy = (st_q != ST_IDLE) || pend_q;
  wire cmd_ok = wr_cmd && !busy;
  wire tmr_end = (tmr_q == '0);
  wire fr_end = (st_q == ST_FR) && tmr_end;
  wire fhold_end = (st_q == ST_FHOLD) && tmr_end;
  wire dr_end = (st_q == ST_DR) && tmr_end;
  wire dhold_end = (st_q == ST_DHOLD) && tmr_end;

  // Operation decode of the pending command word.
  wire [3:0] cmd_op = cmd_q[EB_OP_HI:EB_OP_LO];
  wire [1:0] cmd_sel = cmd_q[EB_SEL_HI:EB_SEL_LO];
  wire cmd_clr = cmd_q[EB_CLR] && (cmd_sel != SEL_MEM);
  wire is_exc = (cmd_op == 4'h1);
  wire is_sns = (cmd_op == 4'h2);
  wire is_din = (cmd_op == 4'h4);
  wire is_dout = (cmd_op == 4'h8);
  wire cmd_legal = is_exc || is_sns || is_din || is_dout;
  wire [3:0] wcmd_op = hwdata[EB_OP_HI:EB_OP_LO];
  wire wcmd_legal = (wcmd_op == 4'h1) || (wcmd_op == 4'h2) ||
                    (wcmd_op == 4'h4) || (wcmd_op == 4'h8);

  // Traps win over interrupts, which win over program commands.
  wire trap_go = ctrl_q[CTRL_TRAP_EN] && (tout_s || tin_s);
  wire int_go = ctrl_q[CTRL_INT_EN] && prio_q && irq_s;
  wire [2:0] start_op = trap_go ? (tout_s ? OP_TOUT : OP_TIN) :
                        int_go ? OP_INT :
                        (pend_q && is_exc) ? OP_EXC :
                        (pend_q && is_sns) ? OP_SNS :
                        (pend_q && is_din) ? OP_DIN :
                        (pend_q && is_dout) ? OP_DOUT : OP_NONE;

  wire two_phase = (op_q == OP_DIN) || (op_q == OP_DOUT) ||
                   (op_q == OP_TOUT) || (op_q == OP_TIN);
  wire in_phase = (op_q == OP_DIN) || (op_q == OP_TIN);
  wire ack_op_d = (op_d == OP_TOUT) || (op_d == OP_TIN) || (op_d == OP_INT);
  wire out_op_d = (op_d == OP_DOUT) || (op_d == OP_TOUT);
  wire p1_d = (st_d == ST_SETUP) || (st_d == ST_FR) || (st_d == ST_FHOLD);
  wire p2_d = (st_d == ST_GAP) || (st_d == ST_DR) || (st_d == ST_DHOLD);
  wire ack_d = ack_op_d && (p1_d || p2_d);
  wire [EB_W-1:0] out_word = (op_d == OP_TOUT) ? tout_q :
                             (cmd_sel == SEL_A) ? a_q :
                             (cmd_sel == SEL_B) ? b_q : dout_q;

  function automatic logic [TMR_W-1:0] dur(sbp_state_t s, logic inp);
    int n;
    n = 1;
    unique case (s)
      ST_SETUP: n = SETUP_CYC;
      ST_FR: n = FR_CYC;
      ST_FHOLD: n = HOLD_CYC;
      ST_GAP: n = inp ? DIN_CYC : SETUP_CYC;
      ST_DR: n = DR_CYC;
      ST_DHOLD: n = DHOLD_CYC;
      ST_JUMP: n = JUMP_CYC;
      ST_IDLE: n = 1;
    endcase
    return TMR_W'(n - 1);
  endfunction : dur

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    unique case (st_q)
      ST_IDLE: begin
        op_d = sbp_op_t'(start_op);
        st_d = (start_op != OP_NONE) ? ST_SETUP : ST_IDLE;
      end
      ST_SETUP: st_d = tmr_end ? ST_FR : ST_SETUP;
      ST_FR: st_d = tmr_end ? ST_FHOLD : ST_FR;
      ST_FHOLD: begin
        if (tmr_end) begin
          st_d = two_phase ? ST_GAP :
                 (op_q == OP_INT) ? ST_JUMP : ST_IDLE;
        end
      end
      ST_GAP: st_d = tmr_end ? ST_DR : ST_GAP;
      ST_DR: st_d = tmr_end ? ST_DHOLD : ST_DR;
      ST_DHOLD: st_d = tmr_end ? ST_IDLE : ST_DHOLD;
      ST_JUMP: st_d = tmr_end ? ST_IDLE : ST_JUMP;
    endcase
    if (st_d == ST_IDLE) begin
      op_d = OP_NONE;
    end
    tmr_d = (st_d != st_q) ? dur(st_d, in_phase) : tmr_q - 1'b1;
    if (p1_d && !ack_op_d) begin
      ebus_o_d = cmd_q;
    end else if (p2_d && out_op_d) begin
      ebus_o_d = out_word;
    end else begin
      ebus_o_d = '0;
    end
  end

  // Line outputs are the registered image of the next state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      op_q <= OP_NONE;
      tmr_q <= '0;
      ebus_o_q <= '0;
      oe_q <= 1'b0;
      fr_q <= 1'b0;
      dr_q <= 1'b0;
      ack_q <= 1'b0;
      jump_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      tmr_q <= tmr_d;
      ebus_o_q <= ebus_o_d;
      oe_q <= (p1_d && !ack_op_d) || (p2_d && out_op_d);
      fr_q <= (st_d == ST_FR);
      dr_q <= (st_d == ST_DR);
      ack_q <= ack_d;
      jump_q <= (st_d == ST_JUMP);
    end
  end

  // System reset stays true through the computer's own reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysrst_q <= 1'b1;
      prio_q <= 1'b0;
    end else begin
      sysrst_q <= ctrl_q[CTRL_SYSRST];
      prio_q <= ctrl_q[CTRL_PRIO];
    end
  end

  sbp_iuc_div u_iuc (
    .hclk(hclk),
    .hresetn(hresetn),
    .stop(ack_d),
    .iuc(interrupt_clock_line)
  );

  // Command, data and control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= '0;
      pend_q <= 1'b0;
      dout_q <= '0;
      tout_q <= '0;
      ctrl_q <= CTRL_RST;
    end else begin
      cmd_q <= (cmd_ok && wcmd_legal) ? hwdata[EB_W-1:0] : cmd_q;
      pend_q <= (cmd_ok && wcmd_legal) ||
                (pend_q && !(st_q == ST_IDLE && start_op >= OP_EXC &&
                             start_op <= OP_DOUT));
      dout_q <= wr_dout ? hwdata[EB_W-1:0] : dout_q;
      tout_q <= wr_tout ? hwdata[EB_W-1:0] : tout_q;
      ctrl_q <= wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_q;
    end
  end

  // Captures at the trailing edge of each control pulse, sense at the end of the hold after function-ready.
  wire cap_sense = fhold_end && (op_q == OP_SNS);
  wire cap_loc = fr_end && (op_q == OP_INT);
  wire cap_taddr = fr_end && ((op_q == OP_TOUT) || (op_q == OP_TIN));
  wire cap_din = dr_end && (op_q == OP_DIN);
  wire cap_tin = dr_end && (op_q == OP_TIN);
  wire trap_done = dhold_end && ((op_q == OP_TOUT) || (op_q == OP_TIN));
  wire out_clr = dhold_end && (op_q == OP_DOUT) && cmd_clr;
  wire [EB_W-1:0] a_in = (cmd_clr ? '0 : a_q) | eb_s;
  wire [EB_W-1:0] b_in = (cmd_clr ? '0 : b_q) | eb_s;
  wire clr_int = wr_stat && hwdata[STAT_INT];
  wire clr_trap = wr_stat && hwdata[STAT_TRAP];
  wire clr_err = wr_stat && hwdata[STAT_ERR];
  wire set_err = wr_cmd && (busy || !wcmd_legal);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_q <= 1'b0;
      taddr_q <= '0;
      din_q <= '0;
      tin_q <= '0;
      tdir_q <= 1'b0;
    end else begin
      sense_q <= cap_sense ? sns_s : sense_q;
      taddr_q <= cap_loc ? {eb_s[EB_W-1:EB_LOC_LO], 1'b0} :
                 cap_taddr ? eb_s : taddr_q;
      din_q <= (cap_din && cmd_sel == SEL_MEM) ? eb_s : din_q;
      tin_q <= cap_tin ? eb_s : tin_q;
      tdir_q <= cap_taddr ? (op_q == OP_TIN) : tdir_q;
    end
  end

  // Input ORs into a register unless the command clears it first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= wr_a ? hwdata[EB_W-1:0] :
             (cap_din && cmd_sel == SEL_A) ? a_in :
             (out_clr && cmd_sel == SEL_A) ? '0 : a_q;
      b_q <= wr_b ? hwdata[EB_W-1:0] :
             (cap_din && cmd_sel == SEL_B) ? b_in :
             (out_clr && cmd_sel == SEL_B) ? '0 : b_q;
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_q <= 1'b0;
      trap_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      int_q <= cap_loc || (int_q && !clr_int);
      trap_q <= trap_done || (trap_q && !clr_trap);
      err_q <= set_err || (err_q && !clr_err);
    end
  end

  always_comb begin
    stat_w = '0;
    stat_w[STAT_BUSY] = busy;
    stat_w[STAT_SENSE] = sense_q;
    stat_w[STAT_INT] = int_q;
    stat_w[STAT_TRAP] = trap_q;
    stat_w[STAT_ERR] = err_q;
    stat_w[STAT_PRIO_IN] = pin_s;
    stat_w[STAT_IRQ] = irq_s;
    stat_w[STAT_TRAP_IN] = tdir_q;
  end

  assign rd_w = (ra == REG_CMD) ? {16'h0000, cmd_q} :
                (ra == REG_DOUT) ? {16'h0000, dout_q} :
                (ra == REG_STAT) ? stat_w :
                (ra == REG_DIN) ? {16'h0000, din_q} :
                (ra == REG_CTRL) ? {28'h0000000, ctrl_q} :
                (ra == REG_TADDR) ? {16'h0000, taddr_q} :
                (ra == REG_TOUT) ? {16'h0000, tout_q} :
                (ra == REG_TIN) ? {16'h0000, tin_q} :
                (ra == REG_AREG) ? {16'h0000, a_q} :
                (ra == REG_BREG) ? {16'h0000, b_q} : 32'h00000000;

  assign ebus_o = ebus_o_q;
  assign ebus_oe = oe_q;
  assign function_ready_pulse = fr_q;
  assign data_ready_pulse = dr_q;
  assign interrupt_acknowledge_line = ack_q;
  assign interrupt_jump_line = jump_q;
  assign system_reset_line = sysrst_q;
  assign priority_out_line = prio_q;

  // Checks on the line sequencing.
  localparam int FR_M1 = FR_CYC - 1;
  localparam int DR_M1 = DR_CYC - 1;
  localparam int DR_MAX = HOLD_CYC + DIN_CYC + 2;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence fr_pulse_s;
    ##FR_M1 fr_q ##1 !fr_q;
  endsequence
  sequence second_phase_s;
    ##[1:DR_MAX] $rose(dr_q);
  endsequence

  fr_width_a: assert property ($rose(fr_q) |-> fr_pulse_s)
    else $error("function-ready pulse width wrong");
  dr_width_a: assert property ($rose(dr_q) |->
      ##DR_M1 dr_q ##1 !dr_q)
    else $error("data-ready pulse width wrong");
  code_on_bus_a: assert property (fr_q && !ack_q |-> oe_q &&
      $onehot(ebus_o_q[EB_OP_HI:EB_OP_LO]))
    else $error("no operation code under function-ready");
  one_phase_a: assert property (dr_q |-> two_phase)
    else $error("data-ready in a single-phase operation");
  two_phase_a: assert property ($fell(fr_q) && two_phase |->
      second_phase_s)
    else $error("second phase missing");
  trap_ack_a: assert property ((fr_q || dr_q) &&
      (op_q == OP_TOUT || op_q == OP_TIN) |-> ack_q && !(fr_q && oe_q))
    else $error("trap pulse without acknowledge");
  iuc_stop_a: assert property (ack_q |->
      !interrupt_clock_line)
    else $error("interrupt clock runs under acknowledge");
  jump_after_a: assert property ($fell(ack_q) && op_q == OP_INT |->
      jump_q ##1 jump_q)
    else $error("interrupt jump not shown");
  reg_clear_a: assert property (out_clr && !wr_a && !wr_b |=>
      (a_q == '0 || cmd_sel != SEL_A) && (b_q == '0 || cmd_sel != SEL_B))
    else $error("selected register not cleared");

endmodule : sbp_io_port

// File: test/sbp_periph_model.sv
// Behavioural peripheral plus trap and interrupt module on the shared bus.
`timescale 1ns/1ps
module sbp_periph_model #(
  parameter logic [5:0] DEV = 6'h05
) (
  // Clock
  input wire logic hclk,
  // Lines from the computer
  input wire logic [15:0] ebus_o,
  input wire logic ebus_oe,
  input wire logic fr,
  input wire logic dr,
  input wire logic ack,
  input wire logic sysrst,
  input wire logic prio_out,
  // Scenario controls
  input wire logic sense_state,
  input wire logic [2:0] want,
  input wire logic [15:0] din_word,
  input wire logic [15:0] mod_addr,
  // Lines to the computer
  output logic [15:0] drv,
  output logic sense_ret = 1'b0,
  output logic [2:0] req,
  output logic prio_in = 1'b0,
  output logic [15:0] got_word = 16'h0
);
  logic fr_q = 1'b0;
  logic dr_q = 1'b0;
  logic in_q = 1'b0;
  logic out_q = 1'b0;
  logic fr_done_q = 1'b0;
  logic [2:0] took_q = 3'h0;
  logic sel;
  logic fr_end;
  // Released lines fall back to the terminated level, which reads as zero.
  assign sel = ebus_oe & (ebus_o[5:0] == DEV) & !ack;
  assign fr_end = fr_q & !fr;
  assign req = want & ~took_q;
  assign drv = (ack & !fr_done_q) ? mod_addr :
    (in_q ? din_word : 16'h0);
  always @(posedge hclk) begin
    fr_q <= fr;
    dr_q <= dr;
    sense_ret <= sel & ebus_o[12] & sense_state;
    prio_in <= prio_out;
    took_q <= want & (took_q | {3{ack}});
    if (fr_end & ack) begin
      fr_done_q <= 1'b1;
    end else if (!ack) begin
      fr_done_q <= 1'b0;
    end
    if (sysrst) begin
      in_q <= 1'b0;
      out_q <= 1'b0;
    end else if (fr_end) begin
      in_q <= (sel & ebus_o[13]) | (ack & want[1]);
      out_q <= (sel & ebus_o[14]) | (ack & want[0]);
    end else if (dr_q & !dr) begin
      if (out_q) begin
        got_word <= ebus_o;
      end
      in_q <= 1'b0;
      out_q <= 1'b0;
    end
  end
endmodule : sbp_periph_model

// File: test/tb_top.sv
// Self-checking bench for the shared bus port.
`timescale 1ns/1ps
module tb_top import sbp_pkg::*; ;
  localparam logic [15:0] DEV = 16'h0005;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hreadyout, hresp, ebus_oe, fr, dr, ack, iuc, jump, sysrst, prio;
  logic sense_ret, prio_in;
  logic [15:0] ebus_o, ebus_i, drv, got_word;
  logic [2:0] req;
  logic sense_state = 1'b0;
  logic [2:0] want = 3'h0;
  logic [15:0] din_word = 16'h0;
  logic [15:0] mod_addr = 16'h0;
  int miscompares = 0;
  int n_compared = 0;
  int dr_cnt = 0;
  assign ebus_i = (ebus_oe ? ebus_o : 16'h0) | drv;
  sbp_io_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ebus_i(ebus_i), .ebus_o(ebus_o),
    .ebus_oe(ebus_oe), .function_ready_pulse(fr), .data_ready_pulse(dr),
    .interrupt_acknowledge_line(ack), .interrupt_clock_line(iuc),
    .interrupt_jump_line(jump), .system_reset_line(sysrst),
    .priority_out_line(prio), .sense_return_line(sense_ret),
    .interrupt_request_line(req[2]), .trap_output_request(req[0]),
    .trap_input_request(req[1]), .priority_in_line(prio_in));
  sbp_periph_model u_peer (.hclk(hclk), .ebus_o(ebus_o), .ebus_oe(ebus_oe),
    .fr(fr), .dr(dr), .ack(ack), .sysrst(sysrst), .prio_out(prio),
    .sense_state(sense_state), .want(want), .din_word(din_word),
    .mod_addr(mod_addr), .drv(drv), .sense_ret(sense_ret), .req(req),
    .prio_in(prio_in), .got_word(got_word));
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge dr) dr_cnt++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // The idle cycle keeps a read from seeing the value before a write.
    @(posedge hclk);
  endtask : ahb
  task automatic wait_stat(input int b, input logic v);
    int i;
    i = 0;
    do begin
      ahb(1'b0, REG_STAT, 32'h0);
      i++;
    end while (rd[b] !== v && i < 300);
    chk(rd[b], v, "status wait");
  endtask : wait_stat
  task automatic do_cmd(input logic [15:0] c);
    ahb(1'b1, REG_CMD, {16'h0, c});
    wait_stat(0, 1'b1);
    wait_stat(0, 1'b0);
  endtask : do_cmd
  task automatic t_reset();
    chk(ebus_oe, 1'b0, "oe after reset");
    ahb(1'b1, REG_CTRL, 32'h1);
    // The reset line is a flop behind the control bit: one more edge.
    @(posedge hclk);
    chk(sysrst, 1'b1, "reset line set");
    ahb(1'b1, REG_CTRL, 32'h0);
    ahb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "okay response");
  endtask : t_reset
  task automatic t_exc();
    int n;
    int d0;
    d0 = dr_cnt;
    ahb(1'b1, REG_CMD, {16'h0, 16'h0940 | DEV});
    n = 0;
    while (fr !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(ebus_o, 16'h0940 | DEV, "control code");
    chk(ebus_oe, 1'b1, "code driven");
    chk(ack, 1'b0, "device address phase");
    n = 0;
    while (fr === 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(n, FR_CYC, "ready pulse width");
    wait_stat(0, 1'b0);
    chk(dr_cnt, d0, "single phase");
  endtask : t_exc
  task automatic t_sense();
    for (int s = 0; s < 3; s++) begin
      sense_state <= (s != 0);
      do_cmd(16'h1080 | (DEV + 16'(s == 2)));
      chk(rd[1], s == 1, "sense result");
    end
  endtask : t_sense
  task automatic t_din();
    din_word <= 16'h1234;
    do_cmd(16'h2000 | DEV);
    ahb(1'b0, REG_DIN, 32'h0);
    chk(rd, 32'h1234, "input to memory");
    ahb(1'b1, REG_AREG, 32'h00f0);
    din_word <= 16'h0f00;
    do_cmd(16'h2040 | DEV);
    ahb(1'b0, REG_AREG, 32'h0);
    chk(rd, 32'h0ff0, "input merged");
    do_cmd(16'h2140 | DEV);
    ahb(1'b0, REG_AREG, 32'h0);
    chk(rd, 32'h0f00, "input replaced");
  endtask : t_din
  task automatic t_dout();
    int d0;
    d0 = dr_cnt;
    ahb(1'b1, REG_DOUT, 32'ha5c3);
    do_cmd(16'h4000 | DEV);
    chk(got_word, 16'ha5c3, "output word");
    chk(dr_cnt, d0 + 1, "two phases");
    ahb(1'b1, REG_BREG, 32'h3c3c);
    do_cmd(16'h4180 | DEV);
    chk(got_word, 16'h3c3c, "output from b");
    ahb(1'b0, REG_BREG, 32'h0);
    chk(rd, 32'h0, "b cleared");
    ahb(1'b1, REG_CMD, {16'h0, 16'h1800 | DEV});
    wait_stat(4, 1'b1);
    ahb(1'b1, REG_STAT, 32'h10);
    wait_stat(4, 1'b0);
  endtask : t_dout
  task automatic t_trap();
    ahb(1'b1, REG_CTRL, 32'h4);
    mod_addr <= 16'h0123;
    ahb(1'b1, REG_TOUT, 32'hbeef);
    want <= 3'b001;
    wait_stat(3, 1'b1);
    want <= 3'b000;
    chk(got_word, 16'hbeef, "trap out word");
    ahb(1'b0, REG_TADDR, 32'h0);
    chk(rd, 32'h0123, "trap address");
    ahb(1'b1, REG_STAT, 32'h8);
    din_word <= 16'h7777;
    want <= 3'b010;
    // The direction bit is set in phase one; wait for the whole trap.
    wait_stat(3, 1'b1);
    chk(rd[7], 1'b1, "trap direction");
    want <= 3'b000;
    ahb(1'b0, REG_TIN, 32'h0);
    chk(rd, 32'h7777, "trap in word");
  endtask : t_trap
  task automatic t_irq();
    int n;
    int k;
    ahb(1'b1, REG_CTRL, 32'ha);
    k = 0;
    repeat (100) @(posedge hclk) k += iuc;
    chk(k != 0, 1'b1, "clock runs");
    chk(prio, 1'b1, "priority out");
    mod_addr <= 16'h0246;
    want <= 3'b100;
    n = 0;
    k = 0;
    while (ack !== 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    while (ack === 1'b1 && n < 600) begin
      k += (iuc !== 1'b0);
      @(posedge hclk);
      n++;
    end
    chk(k, 0, "clock stopped");
    chk(jump, 1'b1, "jump line");
    want <= 3'b000;
    wait_stat(2, 1'b1);
    chk(rd[5], 1'b1, "priority chain");
    ahb(1'b0, REG_TADDR, 32'h0);
    chk(rd, 32'h0246, "location");
  endtask : t_irq
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge hclk);
    chk(sysrst, 1'b1, "reset line in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_exc();
    t_sense();
    t_din();
    t_dout();
    t_trap();
    t_irq();
    conclude();
  end
endmodule : tb_top
